/* core_bus_if.sv */
`timescale 1ns/1ps
// core bus between cpu side and interrupt controller
interface core_bus_if;
  logic [23:0] addr;
  logic        rd;
  logic        wr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        ack;
  logic        irqReq;
  logic        nmiTrap;
  modport device (input addr, rd, wr, wdata, ack,
                  output rdata, irqReq, nmiTrap);
  modport host (output addr, rd, wr, wdata, ack,
                input rdata, irqReq, nmiTrap);
endinterface // core_bus_if

/* icu_assertions.sv */
`timescale 1ns/1ps
// bus-level checks between the cpu end and the controller end
module icu_assertions
  import icu_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // core bus
  input wire logic [23:0] addr,
  input wire logic        rd,
  input wire logic        wr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic        ack,
  input wire logic        irqReq,
  input wire logic        nmiTrap
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  logic enSeen_reg;
  logic lockSeen_reg;
  logic statArm_reg;
  // arming as seen on the bus; a refused enable only weakens the checks
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      enSeen_reg   <= 1'b0;
      lockSeen_reg <= 1'b0;
      statArm_reg  <= 1'b0;
    end else begin
      if (wr && addr == ADDR_NMI_CTRL) begin
        enSeen_reg   <= wdata[NMI_EN_BIT];
        lockSeen_reg <= lockSeen_reg | wdata[NMI_LOCK_BIT];
      end else if (nmiTrap) begin
        enSeen_reg <= 1'b0;
      end
      if (nmiTrap) begin
        statArm_reg <= 1'b0;
      end else if (rd && addr == ADDR_NMI_STAT) begin
        statArm_reg <= 1'b1;
      end
    end
  end

  property p_vecWord;
    rd && addr == ADDR_VECTOR |=> rdata[15:8] == 8'h00;
  endproperty
  a_vecWord: assert property (p_vecWord) else $error("vector high byte");
  property p_ackRange;
    ack && rd |=> rdata[7:0] inside {[8'h10:8'h2f]};
  endproperty
  a_ackRange: assert property (p_ackRange) else $error("ack vector");
  property p_statRes;
    rd && addr == ADDR_NMI_STAT |=> rdata[15:1] == 15'h0000;
  endproperty
  a_statRes: assert property (p_statRes) else $error("status bits");
  property p_statClr;
    rd && addr == ADDR_NMI_STAT && statArm_reg && !nmiTrap |=> !rdata[0];
  endproperty
  a_statClr: assert property (p_statClr) else $error("status kept");
  property p_trapPulse;
    nmiTrap |=> !nmiTrap;
  endproperty
  a_trapPulse: assert property (p_trapPulse) else $error("trap long");
  property p_pendBit0;
    rd && addr == ADDR_PEND_LOW |=> !rdata[0];
  endproperty
  a_pendBit0: assert property (p_pendBit0) else $error("pending bit0");
  property p_trapArmed;
    nmiTrap |-> enSeen_reg || lockSeen_reg;
  endproperty
  a_trapArmed: assert property (p_trapArmed) else $error("trap unarmed");
  property p_lockRead;
    rd && addr == ADDR_NMI_CTRL && lockSeen_reg |=> rdata[NMI_LOCK_BIT];
  endproperty
  a_lockRead: assert property (p_lockRead) else $error("lock lost");
  property p_enRead;
    rd && addr == ADDR_NMI_CTRL && !enSeen_reg |=> !rdata[NMI_EN_BIT];
  endproperty
  a_enRead: assert property (p_enRead) else $error("enable stuck");
endmodule // icu_assertions

/* icu_device.sv */
`timescale 1ns/1ps
// Behaviour
// - nmi off at reset; lock keeps it on
// - plain enable lasts until next nmi
// - 31 level requests, fixed priority, one request
// - cpu takes irq only when globally enabled
// - each source gated by its mask bit
// - request line zero tied inactive
// - vector equals 10h plus request number
// - vector shows highest active enabled request
// - cpu acknowledge reads vector byte
// - code 10h goes to default handler
// - nmi status read-only, cleared on read
// - status bit 0 flags outside nmi
// - trap on falling edge while enabled
// - hardware clears enable on nmi event
// - enable set only while flag clear
// - control bit 1 shows pin state
// - lock set by software, reset clears
// - software writes zeros to reserved bits
// - vector stable during acknowledge cycle
// - low mask resets ones, bit 0 ignored
// - high mask resets ones, bit n irq 16+n
// - pending registers show raw request lines
// - nmi pin synchronised before edge detect
module icu_device
  import icu_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // core bus
  core_bus_if.device       bus,
  // peripheral requests and nmi pin
  input  wire logic [31:1] irqLines,
  input  wire logic        nmiPin_n
);
  typedef struct packed {
    logic [15:0] maskLow;
    logic [15:0] maskHigh;
    logic        nmiEn;
    logic        nmiLock;
    logic        nmiFlag;
    logic [7:0]  vector;
    logic        irqReq;
    logic        nmiTrap;
    logic [15:0] rdata;
  } dev_t;
  dev_t st_reg;
  dev_t st_next;

  logic        pinAsserted;
  logic        fallPulse;
  logic [31:0] pending;
  logic [31:0] enabled;
  logic [31:0] maskWord;
  logic [4:0]  topIdx;
  logic        nmiArmed;
  logic        nmiEvent;
  // one select per register; only the status select feeds a side effect, reads and writes decode bus.addr directly
  logic        selVector;
  logic        selStat;
  logic        selCtrl;
  logic        selPendLow;
  logic        selPendHigh;
  logic        selMaskLow;
  logic        selMaskHigh;
  logic        statRead;
  logic        ctrlWrite;

  // pin arrives asynchronously, so it is synchronised first
  nmi_sync u_sync (
    .clk         (clk),
    .arst_n      (arst_n),
    .nmiPin_n    (nmiPin_n),
    .pinAsserted (pinAsserted),
    .fallPulse   (fallPulse)
  );

  // highest set bit wins; empty gives line zero (code 10h)
  function automatic logic [4:0] top_index(input logic [31:0] v);
    logic [4:0] idx;
    idx = 5'd0;
    for (int i = 1; i < NUM_IRQ; i++) begin
      if (v[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

  // full address match; the bus carries byte addresses
  function automatic logic reg_hit(input logic [23:0] a,
                                   input logic [23:0] target);
    return a == target;
  endfunction

  // raw request lines; nothing drives line zero
  assign pending  = {irqLines, 1'b0};

  // line zero never enables, whatever its mask bit holds
  assign maskWord[0] = 1'b0;

  // one gate per line keeps the mask-to-line mapping in plain view
  for (genvar g = 1; g < NUM_IRQ; g++) begin : g_gate
    if (g < 16) begin : g_low
      assign maskWord[g] = st_reg.maskLow[g];
    end else begin : g_high
      assign maskWord[g] = st_reg.maskHigh[g-16];
    end
  end

  // a line counts only when it is both raised and enabled
  assign enabled  = pending & maskWord;
  assign topIdx   = top_index(enabled);

  // address decode; reads of a wrong address simply return zero
  assign selVector   = reg_hit(bus.addr, ADDR_VECTOR);
  assign selStat     = reg_hit(bus.addr, ADDR_NMI_STAT);
  assign selCtrl     = reg_hit(bus.addr, ADDR_NMI_CTRL);
  assign selPendLow  = reg_hit(bus.addr, ADDR_PEND_LOW);
  assign selPendHigh = reg_hit(bus.addr, ADDR_PEND_HIGH);
  assign selMaskLow  = reg_hit(bus.addr, ADDR_MASK_LOW);
  assign selMaskHigh = reg_hit(bus.addr, ADDR_MASK_HIGH);

  // strobes qualified by their register
  assign statRead  = bus.rd & selStat;
  assign ctrlWrite = bus.wr & selCtrl;

  // the edge is only honoured while one of the two enables stands
  assign nmiArmed = st_reg.nmiLock | st_reg.nmiEn;
  assign nmiEvent = fallPulse & nmiArmed;

  // register file, vector and nmi tracking
  always_comb begin
    st_next         = st_reg;
    st_next.nmiTrap = nmiEvent;
    st_next.irqReq  = |enabled;
    // vector frozen while the cpu is acknowledging
    // while unfrozen the code may move every cycle; only ack is safe
    if (!bus.ack) begin
      st_next.vector = VECTOR_BASE + {3'b000, topIdx};
    end
    // read data mux; unmapped reads return zero
    st_next.rdata = 16'h0000;
    if (bus.rd) begin
      case (bus.addr)
        ADDR_VECTOR:    st_next.rdata = {8'h00, st_next.vector};
        ADDR_NMI_STAT:  st_next.rdata = {15'h0000, st_reg.nmiFlag};
        ADDR_NMI_CTRL:  st_next.rdata = {13'h0000, st_reg.nmiLock,
                                         pinAsserted, st_reg.nmiEn};
        ADDR_PEND_LOW:  st_next.rdata = pending[15:0];
        ADDR_PEND_HIGH: st_next.rdata = pending[31:16];
        ADDR_MASK_LOW:  st_next.rdata = st_reg.maskLow;
        ADDR_MASK_HIGH: st_next.rdata = st_reg.maskHigh;
        default:        st_next.rdata = 16'h0000;
      endcase
    end
    // status read clears flag; a new event in the same cycle wins
    if (statRead) begin
      st_next.nmiFlag = 1'b0;
    end
    if (bus.wr) begin
      case (bus.addr)
        ADDR_MASK_LOW:  st_next.maskLow  = bus.wdata;
        ADDR_MASK_HIGH: st_next.maskHigh = bus.wdata;
        ADDR_NMI_CTRL: begin
          if (bus.wdata[NMI_LOCK_BIT]) begin
            st_next.nmiLock = 1'b1;
          end
          if (!bus.wdata[NMI_EN_BIT]) begin
            st_next.nmiEn = 1'b0;
          end else if (!st_reg.nmiFlag) begin
            st_next.nmiEn = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (nmiEvent) begin
      st_next.nmiFlag = 1'b1;
      st_next.nmiEn   = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg          <= '0;
      st_reg.maskLow  <= MASK_RESET;
      st_reg.maskHigh <= MASK_RESET;
      st_reg.vector   <= VECTOR_BASE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus.rdata   = st_reg.rdata;
  assign bus.irqReq  = st_reg.irqReq;
  assign bus.nmiTrap = st_reg.nmiTrap;
endmodule // icu_device

/* icu_host.sv */
`timescale 1ns/1ps
// cpu-side end: global enable, acknowledge cycle and register access
module icu_host
  import icu_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // core bus
  core_bus_if.host         bus,
  // user command port
  input  wire logic        globalEnable,
  input  wire logic        cmdValid,
  input  wire logic        cmdWrite,
  input  wire logic [23:0] cmdAddr,
  input  wire logic [15:0] cmdWdata,
  output logic             cmdReady,
  output logic             rspValid,
  output logic [15:0]      rspData,
  // taken interrupt
  output logic             irqTaken,
  output logic [7:0]       irqVector,
  output logic             nmiSeen
);
  typedef enum logic [1:0] {IDLE, ACCESS, ACKNOWLEDGE, RESULT} host_state_t;
  typedef struct packed {
    host_state_t state;
    logic [23:0] addr;
    logic        rd;
    logic        wr;
    logic [15:0] wdata;
    logic        ack;
    logic [1:0]  cnt;
    logic        isAck;
    logic        rspValid;
    logic [15:0] rspData;
    logic        irqTaken;
    logic [7:0]  irqVector;
    logic        nmiSeen;
  } host_t;
  host_t st_reg;
  host_t st_next;

  // one access at a time; acknowledge takes priority over commands
  always_comb begin
    st_next          = st_reg;
    st_next.rspValid = 1'b0;
    st_next.irqTaken = 1'b0;
    st_next.nmiSeen  = bus.nmiTrap;
    st_next.rd       = 1'b0;
    st_next.wr       = 1'b0;
    case (st_reg.state)
      IDLE: begin
        if (bus.irqReq && globalEnable) begin
          st_next.ack   = 1'b1;
          st_next.addr  = ADDR_VECTOR;
          st_next.rd    = 1'b1;
          st_next.isAck = 1'b1;
          st_next.cnt   = 2'(ACK_WAIT_CYCLES);
          st_next.state = ACKNOWLEDGE;
        end else if (cmdValid) begin
          st_next.addr  = cmdAddr;
          st_next.rd    = ~cmdWrite;
          st_next.wr    = cmdWrite;
          st_next.wdata = cmdWdata & ((cmdAddr == ADDR_NMI_CTRL) ?
                          16'h0007 : 16'hffff);
          st_next.isAck = 1'b0;
          st_next.state = ACCESS;
        end
      end
      ACCESS: begin
        st_next.state = RESULT;
      end
      ACKNOWLEDGE: begin
        st_next.cnt = st_reg.cnt - 2'd1;
        if (st_reg.cnt == 2'd1) begin
          // read data stands only for the cycle after the strobe
          st_next.irqVector = bus.rdata[7:0];
          st_next.state     = RESULT;
        end
      end
      RESULT: begin
        st_next.ack   = 1'b0;
        st_next.state = IDLE;
        if (st_reg.isAck) begin
          // 10h means the request was withdrawn: default handler
          st_next.irqTaken  = 1'b1;
        end else begin
          st_next.rspValid = ~st_reg.wr;
          st_next.rspData  = bus.rdata;
        end
      end
      default: st_next.state = IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cmdReady  = (st_reg.state == IDLE) & ~(bus.irqReq & globalEnable);
  assign bus.addr  = st_reg.addr;
  assign bus.rd    = st_reg.rd;
  assign bus.wr    = st_reg.wr;
  assign bus.wdata = st_reg.wdata;
  assign bus.ack   = st_reg.ack;
  assign rspValid  = st_reg.rspValid;
  assign rspData   = st_reg.rspData;
  assign irqTaken  = st_reg.irqTaken;
  assign irqVector = st_reg.irqVector;
  assign nmiSeen   = st_reg.nmiSeen;
endmodule // icu_host

/* icu_pkg.sv */
package icu_pkg;
  // register byte addresses on the core bus
  localparam logic [23:0] ADDR_VECTOR    = 24'hff_fe00;
  localparam logic [23:0] ADDR_NMI_STAT  = 24'hff_fe02;
  localparam logic [23:0] ADDR_NMI_CTRL  = 24'hff_fe04;
  localparam logic [23:0] ADDR_PEND_LOW  = 24'hff_fe0a;
  localparam logic [23:0] ADDR_PEND_HIGH = 24'hff_fe0c;
  localparam logic [23:0] ADDR_MASK_LOW  = 24'hff_fe0e;
  localparam logic [23:0] ADDR_MASK_HIGH = 24'hff_fe10;
  // field positions
  localparam int NMI_EN_BIT   = 0;
  localparam int NMI_PIN_BIT  = 1;
  localparam int NMI_LOCK_BIT = 2;
  localparam int NMI_FLAG_BIT = 0;
  // reset values and codes
  localparam logic [15:0] MASK_RESET  = 16'hffff;
  localparam logic [7:0]  VECTOR_BASE = 8'h10;
  localparam int          NUM_IRQ     = 32;
  // host-side cycle counts
  localparam int ACK_WAIT_CYCLES = 2;
endpackage

/* nmi_sync.sv */
`timescale 1ns/1ps
// two-stage synchroniser plus falling-edge detect for the nmi pin
module nmi_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // pin and results
  input  wire logic nmiPin_n,
  output logic      pinAsserted,
  output logic      fallPulse
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_t;
  sync_t st_reg;
  sync_t st_next;

  // s1 feeds only s2; reset to idle-high
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = nmiPin_n;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pinAsserted = ~st_reg.s2;
  assign fallPulse   = st_reg.s3 & ~st_reg.s2;
endmodule // nmi_sync

/* testbench.sv */
`timescale 1ns/1ps
// host end drives the controller end; checks use host commands and outputs and one direct probe of busIf.irqReq
module testbench;
  import icu_pkg::*;
  logic        clk;
  logic        arst_n = 1'b0;
  logic        globalEnable = 1'b0;
  logic        cmdValid = 1'b0;
  logic        cmdWrite = 1'b0;
  logic [23:0] cmdAddr = 24'h00_0000;
  logic [15:0] cmdWdata = 16'h0000;
  logic        cmdReady;
  logic        rspValid;
  logic [15:0] rspData;
  logic        irqTaken;
  logic [7:0]  irqVector;
  logic        nmiSeen;
  logic [31:1] irqLines = '0;
  logic        nmiPin_n = 1'b1;
  logic [7:0]  lastVec = 8'h00;
  logic [15:0] rdVal;
  int          tookCnt = 0;
  int          nmiCnt = 0;
  int          cyc = 0;
  int          failCount = 0;
  int          nCompared = 0;

  core_bus_if busIf ();
  icu_device icu_device_inst (.clk(clk), .arst_n(arst_n), .bus(busIf),
    .irqLines(irqLines), .nmiPin_n(nmiPin_n));
  icu_host icu_host_inst (.clk(clk), .arst_n(arst_n), .bus(busIf),
    .globalEnable(globalEnable), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
    .cmdAddr(cmdAddr), .cmdWdata(cmdWdata), .cmdReady(cmdReady),
    .rspValid(rspValid), .rspData(rspData), .irqTaken(irqTaken),
    .irqVector(irqVector), .nmiSeen(nmiSeen));
  icu_assertions icu_assertions_inst (.clk(clk), .arst_n(arst_n),
    .addr(busIf.addr), .rd(busIf.rd), .wr(busIf.wr), .wdata(busIf.wdata),
    .rdata(busIf.rdata), .ack(busIf.ack), .irqReq(busIf.irqReq),
    .nmiTrap(busIf.nmiTrap));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // pulses are caught mid-cycle so no edge race decides the count
  always @(negedge clk) begin
    cyc++;
    if (irqTaken === 1'b1) begin
      tookCnt++;
      lastVec = irqVector;
    end
    if (nmiSeen === 1'b1) nmiCnt++;
    if (cyc > 3000) begin
      failCount++;
      finishTest();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    nCompared++;
    if (got !== exp) begin
      failCount++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one host command, held until taken; read data lands in rdVal
  task automatic access(input logic w, input logic [23:0] a,
                        input logic [15:0] d);
    cmdValid = 1'b1;
    cmdWrite = w;
    cmdAddr = a;
    cmdWdata = d;
    while (cmdReady !== 1'b1) @(negedge clk);
    @(negedge clk);
    cmdValid = 1'b0;
    while (!w && rspValid !== 1'b1) @(negedge clk);
    if (w) @(negedge clk);
    rdVal = rspData;
  endtask

  task automatic rdChk(input logic [23:0] a, input logic [15:0] exp);
    access(1'b0, a, 16'h0000);
    check(rdVal, exp);
  endtask

  // the synchroniser needs a few cycles on each level
  task automatic nmiFall();
    nmiPin_n = 1'b0;
    repeat (8) @(negedge clk);
    nmiPin_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask

  task automatic finishTest();
    $display("compared %0d mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    rdChk(ADDR_MASK_LOW, 16'hffff);
    rdChk(ADDR_MASK_HIGH, 16'hffff);
    rdChk(ADDR_NMI_CTRL, 16'h0000);
    rdChk(ADDR_NMI_STAT, 16'h0000);
    rdChk(ADDR_VECTOR, 16'h0010);
    rdChk(24'hff_fe08, 16'h0000);
    // growing set of lines: the top one must win
    for (int i = 1; i < 32; i++) begin
      irqLines = {31{1'b1}} >> (31 - i);
      rdChk(ADDR_VECTOR, 16'h0010 + 16'(i));
    end
    rdChk(ADDR_PEND_LOW, 16'hfffe);
    access(1'b1, ADDR_MASK_HIGH, 16'h7fff);
    rdChk(ADDR_VECTOR, 16'h002e);
    access(1'b1, ADDR_MASK_HIGH, 16'h0000);
    rdChk(ADDR_VECTOR, 16'h001f);
    access(1'b1, ADDR_MASK_LOW, 16'h0001);
    rdChk(ADDR_VECTOR, 16'h0010);
    check({15'h0000, busIf.irqReq}, 16'h0000);
    rdChk(ADDR_PEND_HIGH, 16'hffff);
    access(1'b1, ADDR_MASK_LOW, 16'hffff);
    access(1'b1, ADDR_MASK_HIGH, 16'hffff);
    // line 5 alone; cpu globally off first
    irqLines = 31'h0000_0010;
    repeat (10) @(negedge clk);
    check(16'(tookCnt), 16'h0000);
    globalEnable = 1'b1;
    while (tookCnt == 0) @(negedge clk);
    globalEnable = 1'b0;
    check({8'h00, lastVec}, 16'h0015);
    irqLines = '0;
    // pin low while disarmed: seen in control, no trap
    nmiPin_n = 1'b0;
    repeat (4) @(negedge clk);
    rdChk(ADDR_NMI_CTRL, 16'h0002);
    nmiPin_n = 1'b1;
    repeat (8) @(negedge clk);
    check(16'(nmiCnt), 16'h0000);
    access(1'b1, ADDR_NMI_CTRL, 16'h0001);
    nmiFall();
    check(16'(nmiCnt), 16'h0001);
    rdChk(ADDR_NMI_CTRL, 16'h0000);
    access(1'b1, ADDR_NMI_CTRL, 16'h0001);
    rdChk(ADDR_NMI_CTRL, 16'h0000);
    rdChk(ADDR_NMI_STAT, 16'h0001);
    rdChk(ADDR_NMI_STAT, 16'h0000);
    nmiFall();
    check(16'(nmiCnt), 16'h0001);
    access(1'b1, ADDR_NMI_CTRL, 16'h0004);
    access(1'b1, ADDR_NMI_CTRL, 16'h0000);
    rdChk(ADDR_NMI_CTRL, 16'h0004);
    nmiFall();
    nmiFall();
    check(16'(nmiCnt), 16'h0003);
    rdChk(ADDR_NMI_STAT, 16'h0001);
    finishTest();
  end
endmodule // testbench
